// >>> test_vpd_decoder.sv
// Bench for the vicinity downlink decoder
`timescale 1ns/1ps
`default_nettype none
module test_vpd_decoder;
    import vpd_pkg::*;
    localparam int PU_MIN = (POWERUP_TICK - 1) * (TICK_NS / CLK_NS);
    localparam int LIMIT  = 90000;
    logic       clk, rst, tx_busy, out_ready, pause_pin, ref_clk, hold;
    logic       out_valid, frame_start, frame_end, frame_err, frame_active, rx_ready;
    logic [7:0] out_data, frame_bytes, end_bytes, rnd;
    vpd_mode_t  frame_mode, end_mode;
    int         fails, total_checks, n_start, n_end, n_err, up_cyc, cyc, seed;
    logic [7:0] exp_q[$];

    vpd_reader_model vpd_reader_model_inst (.pause_pin(pause_pin), .ref_clk(ref_clk));
    vpd_decoder vpd_decoder_inst (
        .clk(clk), .rst(rst), .pause_pin(pause_pin), .ref_clk(ref_clk), .tx_busy(tx_busy),
        .out_ready(out_ready), .out_data(out_data), .out_valid(out_valid),
        .frame_start(frame_start), .frame_end(frame_end), .frame_err(frame_err),
        .frame_mode(frame_mode), .frame_active(frame_active), .rx_ready(rx_ready),
        .frame_bytes(frame_bytes));

    // Core clock, 25 MHz
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test;
        if (fails == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Half-slot of the pause for pair k
    function automatic int quad_pos(input logic [7:0] v, input int k);
        return 2 * v[2*k +: 2] + 1;
    endfunction

    task automatic send_sof(input vpd_mode_t m);
        int second;
        second = (m == MODE_QUAD) ? int'(SOF_QUAD_POS) : int'(SOF_BYTE_POS);
        vpd_reader_model_inst.slot(second, 0);
        vpd_reader_model_inst.slot(int'(SOF_LAST) + 1 - second, 0);
    endtask

    task automatic send_quad(input logic [7:0] v);
        int k;
        exp_q.push_back(v);
        for (k = 0; k < 4; k++) vpd_reader_model_inst.slot(2 * QUAD_SLOTS, quad_pos(v, k));
    endtask

    task automatic send_eof;
        vpd_reader_model_inst.slot(int'(EOF_LAST) + 1, 0);
        repeat (1000) @(posedge clk);
    endtask

    // Pulse counts since the last call
    task automatic check_frame(input int s, input int e, input int r);
        check_byte("start pulses", 8'(s), 8'(n_start));
        check_byte("end pulses", 8'(e), 8'(n_end));
        check_byte("discard pulses", 8'(r), 8'(n_err));
        n_start = 0;
        n_end = 0;
        n_err = 0;
    endtask

    // Monitor; random consumer unless held
    always @(posedge clk) begin
        cyc <= cyc + 1;
        up_cyc <= rst ? 0 : up_cyc + 1;
        out_ready <= hold ? 1'b0 : 1'($random(seed));
        if (frame_start === 1'b1) n_start <= n_start + 1;
        if (frame_err === 1'b1) n_err <= n_err + 1;
        if (frame_end === 1'b1) begin
            n_end <= n_end + 1;
            end_bytes <= frame_bytes;
            end_mode <= frame_mode;
        end
        if (rst === 1'b0 && out_valid === 1'b1 && out_ready === 1'b1) begin
            check_byte("out_data", exp_q.size() ? exp_q.pop_front() : 8'hxx, out_data);
        end
        if (cyc == LIMIT) begin
            fails++;
            end_of_test();
        end
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        tx_busy = 1'b0;
        hold = 1'b1;
        out_ready = 1'b0;
        seed = 32'h51ac;
        {fails, total_checks, n_start, n_end, n_err, up_cyc, cyc} = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check_bit("rx_ready at release", 1'b0, rx_ready);
        send_sof(MODE_QUAD);
        while (rx_ready !== 1'b1 && up_cyc < 4000) @(posedge clk);
        check_bit("rx_ready armed", 1'b1, rx_ready);
        check_bit("power-up kept", 1'b1, up_cyc >= PU_MIN);
        check_frame(0, 0, 0);
        // Stalled consumer fills the buffer
        rnd = 8'($random(seed));
        send_sof(MODE_QUAD);
        send_quad(8'he1);
        send_quad(8'h00);
        hold = 1'b0;
        send_quad(8'hff);
        send_quad(rnd);
        send_eof();
        check_frame(1, 1, 0);
        check_bit("quad mode", MODE_QUAD, end_mode);
        check_byte("bytes in frame", 8'h04, end_bytes);
        check_byte("bytes left", 8'h00, 8'(exp_q.size()));
        // One pair (a quarter byte), then end delimiter
        send_sof(MODE_QUAD);
        vpd_reader_model_inst.slot(8, 3);
        send_eof();
        check_frame(1, 0, 1);
        // Pause at an even half
        send_sof(MODE_QUAD);
        vpd_reader_model_inst.slot(8, 2);
        send_eof();
        check_frame(1, 0, 1);
        // Deaf while sending
        @(posedge clk);
        tx_busy <= 1'b1;
        repeat (3) @(posedge clk);
        check_bit("rx_ready while sending", 1'b0, rx_ready);
        send_sof(MODE_QUAD);
        @(posedge clk);
        tx_busy <= 1'b0;
        repeat (3) @(posedge clk);
        check_bit("rx_ready re-armed", 1'b1, rx_ready);
        send_eof();
        check_frame(0, 0, 0);
        // Byte-wide frame without data
        send_sof(MODE_BYTE);
        send_eof();
        check_frame(1, 1, 0);
        check_bit("byte-wide mode", MODE_BYTE, end_mode);
        check_byte("empty frame", 8'h00, end_bytes);
        // Byte-wide first slot, then field drops
        send_sof(MODE_BYTE);
        exp_q.push_back(8'h00);
        vpd_reader_model_inst.slot(3, 1);
        check_byte("first slot byte left", 8'h00, 8'(exp_q.size()));
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        check_bit("out_valid in reset", 1'b0, out_valid);
        check_bit("frame_active in reset", 1'b0, frame_active);
        check_bit("rx_ready in reset", 1'b0, rx_ready);
        end_of_test();
    end
endmodule
`default_nettype wire

// >>> vpd_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module vpd_buf #(
    parameter int W = 8                    // Word width
) (
    input  wire logic         clk,        // Core clock
    input  wire logic         rst,        // Synchronous reset, active high
    input  wire logic         in_valid,   // Word offered
    output logic              in_ready,   // Room for a word
    input  wire logic [W-1:0] in_data,    // Word in
    output logic              out_valid,  // Head entry holds a word
    input  wire logic         out_ready,  // Consumer takes the head
    output logic [W-1:0]      out_data    // Head word, registered
);
    logic         v1;
    logic [W-1:0] d1;
    logic         push;
    logic         pop;

    assign in_ready = !v1;
    assign push     = in_valid && !v1;
    assign pop      = out_valid && out_ready;

    // Head entry drives the outputs straight from flops; second entry absorbs a stall
    always_ff @(posedge clk) begin
        if (rst) begin
            out_valid <= 1'b0;
            v1        <= 1'b0;
            out_data  <= '0;
            d1        <= '0;
        end else if (pop) begin
            if (v1) begin
                out_data <= d1;
                v1       <= push;
                if (push) begin
                    d1 <= in_data;
                end
            end else begin
                out_valid <= push;
                out_data  <= in_data;
            end
        end else if (push) begin
            if (!out_valid) begin
                out_valid <= 1'b1;
                out_data  <= in_data;
            end else begin
                v1 <= 1'b1;
                d1 <= in_data;
            end
        end
    end
endmodule
`default_nettype wire

// >>> vpd_decoder.sv
// Vicinity downlink decoder: delimiters, pulse-position symbols, byte output
// Overview of operation
// R01: Pauses are taken from the demodulated stream alike whether the reader used 10% or 100% depth.
// R02: In byte-wide mode one pause in one of 256 slots of 18.88 us gives the byte as its slot index.
// R03: The pause lies in the second half of its slot and is credited to that slot.
// R04: In byte-wide mode the first slot decodes as 00h and the last as FFh, linearly between.
// R05: Each byte-wide symbol lasts a fixed 4.833 ms before the next one starts.
// R06: In quad mode one pause in one of four 18.88 us slots gives two bits as its slot index.
// R07: Four quad symbols make a byte, the first pair landing in the lowest bits.
// R08: Each quad byte lasts a fixed 302.08 us before the next one starts.
// R09: Frames open and close with delimiters built from code violations, never taken as data.
// R10: The start delimiter chooses byte-wide or quad coding for the whole frame.
// R11: One end delimiter, the same for both modes, closes a frame.
// R12: After the tag stops sending, its receiver is armed again within 311.5 us.
// R13: After field activation the receiver stays blind for 0.1 ms of power-up.
// R14: The reader talks first; the tag never receives while it is itself sending.
// R15: The reader's carrier is 13.56 MHz within 7 kHz and one slot is 256 carrier periods.
// R16: A misplaced pause or a second pause in one symbol discards the frame.
`timescale 1ns/1ps
`default_nettype none
module vpd_decoder (
    input  wire logic              clk,          // Core clock, 25 MHz
    input  wire logic              rst,          // Field activation reset, active high
    input  wire logic              pause_pin,    // Demodulated pause, high in a pause
    input  wire logic              ref_clk,      // Carrier-derived reference clock
    input  wire logic              tx_busy,      // Tag response in progress
    input  wire logic              out_ready,    // Consumer takes a byte
    output logic [7:0]             out_data,     // Received byte
    output logic                   out_valid,    // Byte available
    output logic                   frame_start,  // Pulse: valid start delimiter
    output logic                   frame_end,    // Pulse: frame closed cleanly
    output logic                   frame_err,    // Pulse: frame discarded
    output vpd_pkg::vpd_mode_t     frame_mode,   // Coding of the current frame
    output logic                   frame_active, // Inside a frame's data
    output logic                   rx_ready,     // Receiver armed
    output logic [7:0]             frame_bytes   // Bytes in the current frame
);
    import vpd_pkg::*;

    logic              pause_lvl;
    logic              ref_lvl;
    logic              pause_q;
    logic              ref_q;
    logic              pause_start;
    logic              tick;
    logic [PU_W-1:0]   pu_cnt;
    logic              powered;
    vpd_state_t        state;
    logic [SUB_W-1:0]  sub;
    logic [HIDX_W-1:0] hidx;
    logic [HIDX_W-1:0] sym_last;
    logic              half_end;
    logic              sym_end;
    logic [SUB_W-1:0]  pause_len;
    logic              pause_long;
    logic              seen;
    logic [1:0]        pairs;
    logic [5:0]        shreg;
    logic              push;
    logic [7:0]        push_data;
    logic              buf_ready;

    // Async pins pass four flops before use
    vpd_sync u_pause_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (pause_pin),
        .dout (pause_lvl)
    );

    vpd_sync u_ref_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (ref_clk),
        .dout (ref_lvl)
    );

    // Previous levels for edge finding
    always_ff @(posedge clk) begin
        if (rst) begin
            pause_q <= 1'b0;
            ref_q   <= 1'b0;
        end else begin
            pause_q <= pause_lvl;
            ref_q   <= ref_lvl;
        end
    end

    // Only the leading edge of a pause counts, as its trailing edge moves with depth
    assign pause_start = pause_lvl && !pause_q;  // see R01
    // Both reference edges advance time, halving the quantisation step
    assign tick        = ref_lvl != ref_q;       // see R15

    // Power-up blind time counted on reference edges
    always_ff @(posedge clk) begin
        if (rst) begin
            pu_cnt  <= '0;
            powered <= 1'b0;
        end else if (!powered && tick) begin
            pu_cnt <= pu_cnt + 1'b1;
            if (pu_cnt == PU_LAST) begin
                powered <= 1'b1;                 // see R13
            end
        end
    end

    // Armed once powered and not sending; re-arms on the cycle after sending ends
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_ready <= 1'b0;
        end else begin
            rx_ready <= powered && !tx_busy;     // see R12 see R14
        end
    end

    // Last half-slot index of the current period, by state and mode
    always_comb begin
        sym_last = SOF_LAST;
        unique case (state)
            ST_SOF:  sym_last = SOF_LAST;
            ST_EOF:  sym_last = EOF_LAST;
            ST_DATA: begin
                if (frame_mode == MODE_QUAD) begin
                    sym_last = QUAD_LAST;        // see R06 see R08
                end else begin
                    sym_last = BYTE_LAST;        // see R02 see R05
                end
            end
            default: sym_last = SOF_LAST;
        endcase
    end

    assign half_end = tick && (sub == SUB_LAST);
    assign sym_end  = half_end && (hidx == sym_last);

    // Half-slot position counter; phase set at the first delimiter pause
    always_ff @(posedge clk) begin
        if (rst) begin
            sub  <= '0;
            hidx <= '0;
        end else if (state == ST_IDLE && pause_start) begin
            sub  <= SUB_MID;                     // see R03
            hidx <= '0;
        end else if (half_end) begin
            sub <= '0;
            if (hidx == sym_last) begin
                hidx <= '0;
            end else begin
                hidx <= hidx + 1'b1;
            end
        end else if (tick) begin
            sub <= sub + 1'b1;
        end
    end

    // Pause width watch: a pause outlasting a half slot is no legal pause
    always_ff @(posedge clk) begin
        if (rst) begin
            pause_len  <= '0;
            pause_long <= 1'b0;
        end else if (!pause_lvl) begin
            pause_len  <= '0;
            pause_long <= 1'b0;
        end else if (tick && !pause_long) begin
            pause_len <= pause_len + 1'b1;
            if (pause_len == PAUSE_MAX) begin
                pause_long <= 1'b1;
            end
        end
    end

    // Frame sequencer, symbol decode and byte assembly
    always_ff @(posedge clk) begin
        if (rst) begin
            state       <= ST_OFF;
            frame_mode  <= MODE_BYTE;
            seen        <= 1'b0;
            pairs       <= '0;
            shreg       <= '0;
            push        <= 1'b0;
            push_data   <= '0;
            frame_start <= 1'b0;
            frame_end   <= 1'b0;
            frame_err   <= 1'b0;
        end else begin
            push        <= 1'b0;
            frame_start <= 1'b0;
            frame_end   <= 1'b0;
            frame_err   <= 1'b0;
            unique case (state)
                ST_OFF: begin
                    if (rx_ready) begin
                        state <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    seen <= 1'b0;
                    if (!rx_ready) begin
                        state <= ST_OFF;         // see R14
                    end else if (pause_start) begin
                        state <= ST_SOF;
                    end
                end
                ST_SOF: begin
                    // Second pause at half SOF_QUAD_POS (5) or SOF_BYTE_POS (6) of the delimiter picks the mode
                    if (!rx_ready) begin
                        state <= ST_OFF;
                    end else if (pause_start) begin
                        if (!seen && hidx == SOF_QUAD_POS) begin
                            frame_mode <= MODE_QUAD; // see R09 see R10
                            seen       <= 1'b1;
                        end else if (!seen && hidx == SOF_BYTE_POS) begin
                            frame_mode <= MODE_BYTE; // see R09 see R10
                            seen       <= 1'b1;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end else if (sym_end) begin
                        if (seen) begin
                            state       <= ST_DATA;
                            frame_start <= 1'b1;
                        end else begin
                            state <= ST_IDLE;
                        end
                        seen  <= 1'b0;
                        pairs <= '0;
                    end
                end
                ST_DATA: begin
                    if (!rx_ready || pause_long) begin
                        state     <= ST_IDLE;    // see R16
                        frame_err <= 1'b1;
                    end else if (pause_start && hidx == POS_ZERO && !seen) begin
                        // Pause on a symbol boundary is the end delimiter
                        state <= ST_EOF;         // see R09 see R11
                        if (pairs != '0) begin
                            frame_err <= 1'b1;
                        end else begin
                            frame_end <= 1'b1;
                        end
                    end else if (pause_start && (!hidx[0] || seen)) begin
                        state     <= ST_IDLE;    // see R16
                        frame_err <= 1'b1;
                    end else if (sym_end && !seen && !pause_start) begin
                        state     <= ST_IDLE;    // see R16
                        frame_err <= 1'b1;
                    end else begin
                        if (pause_start) begin
                            if (frame_mode == MODE_QUAD) begin
                                // First pair lands lowest, later pairs shift in above
                                shreg <= {hidx[2:1], shreg[5:2]};   // see R07
                                pairs <= pairs + 1'b1;
                                if (pairs == PAIR_LAST) begin
                                    push      <= 1'b1;
                                    push_data <= {hidx[2:1], shreg}; // see R06 see R07
                                end
                            end else begin
                                push      <= 1'b1;
                                push_data <= hidx[8:1];              // see R02 see R04
                            end
                        end
                        // Symbols follow back to back on the fixed grid
                        if (sym_end) begin
                            seen <= 1'b0;                            // see R05 see R08
                        end else if (pause_start) begin
                            seen <= 1'b1;
                        end
                    end
                    // A byte with no room means the consumer stalled too long
                    if (push && !buf_ready) begin
                        state     <= ST_IDLE;
                        frame_err <= 1'b1;
                    end
                end
                ST_EOF: begin
                    // Tail pauses of the end delimiter are ignored
                    if (sym_end || !rx_ready) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_OFF;
            endcase
        end
    end

    // Status flags and per-frame byte count
    always_ff @(posedge clk) begin
        if (rst) begin
            frame_active <= 1'b0;
            frame_bytes  <= '0;
        end else begin
            frame_active <= state == ST_DATA;
            if (frame_start) begin
                frame_bytes <= '0;
            end else if (push && buf_ready) begin
                frame_bytes <= frame_bytes + 1'b1;
            end
        end
    end

    // Two entries ride out a short consumer stall without losing a byte
    vpd_buf #(
        .W (8)
    ) u_buf (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (buf_ready),
        .in_data   (push_data),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );
endmodule
`default_nettype wire

// >>> vpd_decoder_properties.sv
// Port-level checks of the vicinity downlink decoder
`timescale 1ns/1ps
`default_nettype none
module vpd_decoder_checker (
    input wire logic               clk,          // Core clock
    input wire logic               rst,          // Reset
    input wire logic               tx_busy,      // Tag sending
    input wire logic               out_ready,    // Consumer takes
    input wire logic [7:0]         out_data,     // Byte
    input wire logic               out_valid,    // Byte held
    input wire logic               frame_start,  // Start pulse
    input wire logic               frame_end,    // End pulse
    input wire logic               frame_err,    // Error pulse
    input wire vpd_pkg::vpd_mode_t frame_mode,   // Coding
    input wire logic               frame_active, // Data phase
    input wire logic               rx_ready,     // Armed
    input wire logic [7:0]         frame_bytes   // Byte count
);
    import vpd_pkg::*;
    localparam int PU_MIN = (POWERUP_TICK - 1) * (TICK_NS / CLK_NS);
    logic [11:0] up_cnt;
    logic        powered;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Cycles since release, saturating
    always_ff @(posedge clk) begin
        if (rst) up_cnt <= 12'h000;
        else if (up_cnt != 12'hfff) up_cnt <= up_cnt + 12'h001;
    end
    // Re-arm owed only once powered up
    always_ff @(posedge clk) begin
        if (rst) powered <= 1'b0;
        else if (rx_ready) powered <= 1'b1;
    end
    sequence s_close; ##[1:3] !frame_active; endsequence
    sequence s_rearm; ##[0:2] rx_ready; endsequence
    property p_mode_stable; frame_active && $past(frame_active) |-> $stable(frame_mode); endproperty
    property p_start_pulse; frame_start |=> !frame_start; endproperty
    property p_end_excl; !(frame_end && frame_err); endproperty
    property p_close; frame_end || frame_err |-> s_close; endproperty
    property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
    property p_bytes_step;
        frame_bytes != $past(frame_bytes) |->
            frame_bytes == $past(frame_bytes) + 8'h01 || frame_bytes == 8'h00;
    endproperty
    property p_busy; tx_busy |=> !rx_ready; endproperty
    property p_rearm; powered && $fell(tx_busy) |-> s_rearm; endproperty
    property p_powerup; rx_ready |-> up_cnt >= PU_MIN; endproperty
    a_mode_stable: assert property (p_mode_stable)
        else $error("mode moved in frame");
    a_start_pulse: assert property (p_start_pulse)
        else $error("start pulse too long");
    a_end_excl: assert property (p_end_excl)
        else $error("end and discard together");
    a_close: assert property (p_close)
        else $error("data phase outlived close");
    a_hold: assert property (p_hold)
        else $error("byte lost in stall");
    a_bytes_step: assert property (p_bytes_step)
        else $error("byte count jumped");
    a_busy: assert property (p_busy)
        else $error("armed while sending");
    a_rearm: assert property (p_rearm)
        else $error("not re-armed");
    a_powerup: assert property (p_powerup)
        else $error("armed before power-up");
endmodule
bind vpd_decoder vpd_decoder_checker vpd_decoder_checker_inst (
    .clk(clk), .rst(rst), .tx_busy(tx_busy), .out_ready(out_ready), .out_data(out_data),
    .out_valid(out_valid), .frame_start(frame_start), .frame_end(frame_end),
    .frame_err(frame_err), .frame_mode(frame_mode), .frame_active(frame_active),
    .rx_ready(rx_ready), .frame_bytes(frame_bytes));
`default_nettype wire

// >>> vpd_pkg.sv
// Shared constants and types for the vicinity downlink pulse-position decoder
package vpd_pkg;
    // Time base: the core clock and the edges of the reference clock
    localparam int CLK_NS         = 40;       // Core clock period
    localparam int TICK_NS        = 160;      // Spacing of reference clock edges
    localparam int SLOT_NS        = 18880;    // One slot, 256 carrier periods
    localparam int HALF_NS        = SLOT_NS / 2;
    localparam int HALF_TICK      = HALF_NS / TICK_NS;
    localparam int POWERUP_NS     = 100000;   // Blind time after field activation
    localparam int POWERUP_TICK   = (POWERUP_NS + TICK_NS - 1) / TICK_NS;
    localparam int TURN_NS        = 311500;   // Latest re-arm after a response
    localparam int TURN_TICK      = TURN_NS / TICK_NS;
    localparam int BYTE256_US     = 4833;     // One byte in byte-wide coding
    localparam int QUAD_BYTE_NS   = 302080;   // One byte in quad coding
    localparam int BYTE_SLOTS     = 256;
    localparam int QUAD_SLOTS     = QUAD_BYTE_NS / 4 / SLOT_NS;

    // Counter widths
    localparam int SUB_W          = 6;
    localparam int HIDX_W         = 10;
    localparam int PU_W           = 10;

    // Sub-half-slot counter limits; start mid-way so positions round
    localparam logic [SUB_W-1:0]  SUB_LAST  = SUB_W'(HALF_TICK - 1);
    localparam logic [SUB_W-1:0]  SUB_MID   = SUB_W'(HALF_TICK / 2);
    localparam logic [SUB_W-1:0]  PAUSE_MAX = SUB_W'(HALF_TICK - 1);

    // Half-slot positions inside delimiters and symbols
    localparam logic [HIDX_W-1:0] SOF_QUAD_POS = 10'h005;
    localparam logic [HIDX_W-1:0] SOF_BYTE_POS = 10'h006;
    localparam logic [HIDX_W-1:0] SOF_LAST     = 10'h007;
    localparam logic [HIDX_W-1:0] EOF_LAST     = 10'h003;
    localparam logic [HIDX_W-1:0] QUAD_LAST    = HIDX_W'(2 * QUAD_SLOTS - 1);
    localparam logic [HIDX_W-1:0] BYTE_LAST    = HIDX_W'(2 * BYTE_SLOTS - 1);
    localparam logic [HIDX_W-1:0] POS_ZERO     = 10'h000;

    localparam logic [PU_W-1:0]   PU_LAST   = PU_W'(POWERUP_TICK - 1);
    localparam logic [1:0]        PAIR_LAST = 2'h3;

    // Receiver states
    typedef enum logic [2:0] {
        ST_OFF  = 3'h0,
        ST_IDLE = 3'h1,
        ST_SOF  = 3'h2,
        ST_DATA = 3'h3,
        ST_EOF  = 3'h4
    } vpd_state_t;

    // Coding mode chosen by the start delimiter
    typedef enum logic {
        MODE_BYTE = 1'b0,
        MODE_QUAD = 1'b1
    } vpd_mode_t;
endpackage

// >>> vpd_reader_model.sv
// Reader model: free-running reference clock and pause stream
`timescale 1ns/1ps
`default_nettype none
module vpd_reader_model (
    output logic pause_pin,  // High in a pause, at any depth
    output logic ref_clk     // Carrier-derived, 320 ns period
);
    import vpd_pkg::*;
    localparam int PAUSE_TICKS = 16;  // Under a half slot
    // Clock runs with the field, frames or not
    initial begin
        ref_clk = 1'b0;
        pause_pin = 1'b0;
        forever #160 ref_clk = ~ref_clk;
    end
    // Symbol of len halves, pause at half pos, odd = second half
    task automatic slot(input int len, input int pos);
        int t;
        for (t = 0; t < len * HALF_TICK; t++) begin
            if (t == pos * HALF_TICK) pause_pin = 1'b1;
            if (t == pos * HALF_TICK + PAUSE_TICKS) pause_pin = 1'b0;
            @(ref_clk);
        end
    endtask
endmodule
`default_nettype wire

// >>> vpd_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module vpd_sync (
    input  wire logic clk,    // Core clock
    input  wire logic rst,    // Synchronous reset, active high
    input  wire logic din,    // Asynchronous input
    output logic      dout    // Filtered level in clk domain
);
    logic s1;
    logic s2;
    logic s3;

    // Stage one feeds stage two only; change taken when two and three agree
    always_ff @(posedge clk) begin
        if (rst) begin
            s1   <= 1'b0;
            s2   <= 1'b0;
            s3   <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule
`default_nettype wire
